//--- pkg/port_a_regs.svh
// Purpose: Register indices, byte addresses, reset values and pin positions
// Assumes: Included by the package, the pin mux, the top level and the testbench
// Notes: A register's byte address is four times its index
`ifndef PORT_A_REGS_SVH
`define PORT_A_REGS_SVH
`define PORT_DIR_IDX 20'hE_E009
`define PORT_DATA_IDX 20'hF_FFD9
`define PORT_DIR_ADDR {`PORT_DIR_IDX, 2'b00}
`define PORT_DATA_ADDR {`PORT_DATA_IDX, 2'b00}
`define PORT_ADDR_W 22
`define PORT_DIR_RST 8'h00
`define PORT_DIR_RST_34 8'h80
`define PORT_DATA_RST 8'h00
`define PORT_DIR_READ 8'hFF
`define PORT_TOP_PIN 7
`define PORT_TOP_MASK 8'h80
`define PORT_TMR_LSB 2
`define PORT_ADDR_LSB 4
`define PORT_CLK_PINS 4
`define PORT_MODE_3 3'h3
`define PORT_MODE_4 3'h4
`define PORT_MODE_5 3'h5
`endif

//--- pkg/port_a_pkg.sv
// Purpose: Types and decode functions shared by the port block
// Assumes: Register constants come from the regs header
// Notes: State of each module is a single packed struct
`include "port_a_regs.svh"
package port_a_pkg;
  typedef logic [7:0] port_t;
  typedef enum logic [1:0] {SEL_NONE, SEL_DIR, SEL_DATA} reg_sel_e;

  typedef struct packed {
    logic wr_act;
    reg_sel_e sel;
    logic [31:0] rdata;
  } slave_s;

  typedef struct packed {
    port_t dir;
    port_t data;
    port_t pin_out;
    port_t pin_oe;
    logic [3:0] tclk;
    logic [5:0] tmr_in;
  } core_s;

  // Byte address to register select; low address bits alias upward
  function automatic reg_sel_e reg_decode(input logic [31:0] addr);
    reg_sel_e sel;
    sel = SEL_NONE;
    if (addr[`PORT_ADDR_W-1:0] == `PORT_DIR_ADDR)
      sel = SEL_DIR;
    else if (addr[`PORT_ADDR_W-1:0] == `PORT_DATA_ADDR)
      sel = SEL_DATA;
    return sel;
  endfunction

  // Modes in which the top pin is tied to address output
  function automatic logic mode_addr_fixed(input logic [2:0] mode);
    return (mode == `PORT_MODE_3) || (mode == `PORT_MODE_4);
  endfunction
endpackage

//--- pkg/port_bus_if.sv
// Purpose: Register strobes between the bus slave and the port core
// Assumes: One clock domain
// Notes: rd_sel is valid only in an accepted read address phase
interface port_bus_if;
  import port_a_pkg::*;
  logic wr_en;
  reg_sel_e wr_sel;
  port_t wdata;
  reg_sel_e rd_sel;
  port_t rdata;
  modport slave (output wr_en, output wr_sel, output wdata, output rd_sel, input rdata);
  modport core (input wr_en, input wr_sel, input wdata, input rd_sel, output rdata);
endinterface

//--- hw/ahb_port_slave.sv
// Purpose: AHB-Lite slave for the two port registers
// Assumes: Single word transfers only; response always OKAY
// Notes: Writes add one wait state so a following read sees new data
module ahb_port_slave
  import port_a_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // AHB-Lite
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // Core side
  port_bus_if.slave bus
);
  slave_s st_reg;
  slave_s st_next;
  logic take;

  // Address phase capture and write commit
  always_comb
  begin
    take = hsel_i && hready_i && htrans_i[1];
    st_next = st_reg;
    st_next.wr_act = 1'b0;
    if (take)
    begin
      st_next.sel = reg_decode(haddr_i);
      st_next.wr_act = hwrite_i;
      st_next.rdata = hwrite_i ? 32'h0000_0000 : 32'(bus.rdata);
    end
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // Strobes to the core
  assign bus.rd_sel = (take && !hwrite_i) ? reg_decode(haddr_i) : SEL_NONE; // Reads only
  assign bus.wr_en = st_reg.wr_act;
  assign bus.wr_sel = st_reg.sel;
  assign bus.wdata = hwdata_i[7:0];
  assign hreadyout_o = !st_reg.wr_act; // Stall during write commit
  assign hresp_o = 1'b0;
  assign hrdata_o = st_reg.rdata;
endmodule

//--- hw/port_pin_mux.sv
// Purpose: Per-pin choice between address, timer, pattern and port drive
// Assumes: Peripheral enables are stable levels
// Notes: Address beats timer beats pattern beats plain port
`include "port_a_regs.svh"
module port_pin_mux #(
  parameter int PINS = 8,
  parameter int TMR_LSB = `PORT_TMR_LSB,
  parameter int ADDR_LSB = `PORT_ADDR_LSB
) (
  // Mode
  input wire logic addr_fixed_i,
  input wire logic addr_mode5_i,
  // Port registers
  input wire logic [PINS-1:0] dir_i,
  input wire logic [PINS-1:0] data_i,
  // Peripherals
  input wire logic [PINS-1:0] pat_en_i,
  input wire logic [PINS-1:0] pat_out_i,
  input wire logic [PINS-TMR_LSB-1:0] tmr_oe_i,
  input wire logic [PINS-TMR_LSB-1:0] tmr_out_i,
  input wire logic [PINS-ADDR_LSB-1:0] addr_en_i,
  input wire logic [PINS-ADDR_LSB-1:0] addr_hi_i,
  // Pin drive
  output logic [PINS-1:0] pin_out_o,
  output logic [PINS-1:0] pin_oe_o
);
  for (genvar k = 0; k < PINS; k++)
  begin : g_pin
    logic a_sel;
    logic a_val;
    logic t_sel;
    logic t_val;
    logic p_sel;
    // Upper pins carry address bits, top pin first
    if (k >= ADDR_LSB)
    begin : g_addr
      assign a_sel = ((k == PINS - 1) && addr_fixed_i)
        || ((addr_fixed_i || addr_mode5_i) && addr_en_i[PINS-1-k]);
      assign a_val = addr_hi_i[PINS-1-k];
    end
    else
    begin : g_no_addr
      assign a_sel = 1'b0;
      assign a_val = 1'b0;
    end
    // Timer channel pins
    if (k >= TMR_LSB)
    begin : g_tmr
      assign t_sel = tmr_oe_i[k-TMR_LSB];
      assign t_val = tmr_out_i[k-TMR_LSB];
    end
    else
    begin : g_no_tmr
      assign t_sel = 1'b0;
      assign t_val = 1'b0;
    end
    // Pattern output needs its direction bit set
    assign p_sel = pat_en_i[k] && dir_i[k];
    // Peripheral drive wins over port drive
    assign pin_oe_o[k] = a_sel || t_sel || p_sel || dir_i[k];
    assign pin_out_o[k] = a_sel ? a_val : t_sel ? t_val : p_sel ? pat_out_i[k] : data_i[k];
  end
endmodule

//--- hw/port_a_top.sv
// Purpose: Eight-pin multiplexed general purpose I/O port with bus registers
// Assumes: Pin and peripheral inputs are synchronous to clock_i
// Notes: Software standby needs no logic; registers simply keep their values
`include "port_a_regs.svh"
module port_a_top
  import port_a_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // AHB-Lite register bus
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // Chip mode and standby
  input wire logic [2:0] mode_i,
  input wire logic hw_standby_i,
  // Pins
  input wire port_a_pkg::port_t pin_i,
  output port_a_pkg::port_t pin_o,
  output port_a_pkg::port_t pin_oe_o,
  // Timing pattern controller
  input wire port_a_pkg::port_t pat_en_i,
  input wire port_a_pkg::port_t pat_out_i,
  // 16-bit timer channels on pins 7 to 2
  input wire logic [5:0] tmr_oe_i,
  input wire logic [5:0] tmr_out_i,
  output logic [5:0] tmr_in_o,
  // External timer clocks on pins 3 to 0
  output logic [3:0] tmr16_clk_o,
  output logic [3:0] tmr8_clk_o,
  // Upper address bits, index 0 is address bit 20
  input wire logic [3:0] addr_en_i,
  input wire logic [3:0] addr_hi_i
);
  core_s st_reg;
  core_s st_next;
  logic addr_fixed;
  logic addr_mode5;
  port_t dir_eff;
  port_t mux_out;
  port_t mux_oe;

  port_bus_if bus ();

  // Bus slave
  ahb_port_slave u_slave (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .hsel_i(hsel_i),
    .haddr_i(haddr_i),
    .htrans_i(htrans_i),
    .hwrite_i(hwrite_i),
    .hwdata_i(hwdata_i),
    .hready_i(hready_i),
    .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o),
    .hrdata_o(hrdata_o),
    .bus(bus)
  );

  // Mode decode and effective direction
  assign addr_fixed = mode_addr_fixed(mode_i);
  assign addr_mode5 = (mode_i == `PORT_MODE_5);
  assign dir_eff = st_reg.dir | (addr_fixed ? `PORT_TOP_MASK : `PORT_DIR_RST);

  // Pin function selection
  port_pin_mux #(
    .PINS(8),
    .TMR_LSB(`PORT_TMR_LSB),
    .ADDR_LSB(`PORT_ADDR_LSB)
  ) u_mux (
    .addr_fixed_i(addr_fixed),
    .addr_mode5_i(addr_mode5),
    .dir_i(dir_eff),
    .data_i(st_reg.data),
    .pat_en_i(pat_en_i),
    .pat_out_i(pat_out_i),
    .tmr_oe_i(tmr_oe_i),
    .tmr_out_i(tmr_out_i),
    .addr_en_i(addr_en_i),
    .addr_hi_i(addr_hi_i),
    .pin_out_o(mux_out),
    .pin_oe_o(mux_oe)
  );

  // Read data: direction reads all ones; port data gives stored bit for outputs, pin level for inputs
  always_comb
  begin
    case (bus.rd_sel)
      SEL_DIR: bus.rdata = `PORT_DIR_READ;
      SEL_DATA: bus.rdata = (dir_eff & st_reg.data) | (~dir_eff & pin_i);
      default: bus.rdata = `PORT_DATA_RST;
    endcase
  end

  // Register updates and registered pin drive
  always_comb
  begin
    st_next = st_reg;
    if (hw_standby_i)
    begin
      st_next.dir = addr_fixed ? `PORT_DIR_RST_34 : `PORT_DIR_RST;
      st_next.data = `PORT_DATA_RST;
    end
    else if (bus.wr_en && bus.wr_sel == SEL_DIR)
      st_next.dir = bus.wdata;
    else if (bus.wr_en && bus.wr_sel == SEL_DATA)
      st_next.data = bus.wdata;
    if (addr_fixed)
      st_next.dir[`PORT_TOP_PIN] = 1'b1;
    st_next.pin_out = mux_out;
    st_next.pin_oe = mux_oe;
    st_next.tclk = pin_i[`PORT_CLK_PINS-1:0];
    st_next.tmr_in = pin_i[7:`PORT_TMR_LSB];
  end

  // Async reset to constants; mode-dependent bit follows at first edge
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // Outputs straight from flip-flops
  assign pin_o = st_reg.pin_out;
  assign pin_oe_o = st_reg.pin_oe;
  assign tmr16_clk_o = st_reg.tclk;
  assign tmr8_clk_o = st_reg.tclk;
  assign tmr_in_o = st_reg.tmr_in;

  default clocking cb @(posedge clock_i);
  endclocking

  default disable iff (reset_i);

  // Top pin held as address bit 20 in modes 3 and 4
  chk_top_pin_addr: assert property (
    !$past(reset_i) && addr_fixed && $past(addr_fixed)
      |-> pin_oe_o[7] && pin_o[7] == $past(addr_hi_i[0]))
    else $error("top pin not driving address bit 20");

  // Stored top direction bit stays set in modes 3 and 4
  chk_top_dir_set: assert property (
    addr_fixed ##1 addr_fixed |-> st_reg.dir[`PORT_TOP_PIN])
    else $error("top direction bit not fixed at one");

  // Hardware standby loads mode-dependent reset values
  chk_standby_load: assert property (
    hw_standby_i && $stable(mode_i) |=>
      st_reg.dir == ($past(addr_fixed) ? `PORT_DIR_RST_34 : `PORT_DIR_RST)
      && st_reg.data == `PORT_DATA_RST)
    else $error("standby did not load reset values");

  // Two standby cycles with no peripheral leave no pin driven, except the top pin in modes 3 and 4
  chk_standby_input: assert property (
    hw_standby_i ##1 hw_standby_i && $stable(mode_i) && tmr_oe_i == 6'h00
      && addr_en_i == 4'h0 && pat_en_i == `PORT_DATA_RST
      |=> pin_oe_o == ($past(addr_fixed) ? `PORT_TOP_MASK : `PORT_DIR_RST))
    else $error("pins not inputs after standby");

  // Registers hold without a write or a standby request
  chk_regs_retain: assert property (
    !bus.wr_en && !hw_standby_i && $stable(mode_i) && (st_reg.dir[7] || !addr_fixed)
      |=> $stable(st_reg.data) && $stable(st_reg.dir))
    else $error("register changed without cause");

  // Data written over the bus lands in the data register
  chk_data_write: assert property (
    bus.wr_en && bus.wr_sel == SEL_DATA && !hw_standby_i |=> st_reg.data == $past(hwdata_i[7:0]))
    else $error("data write lost");

  // Plain port pins follow direction and data
  chk_port_drive: assert property (
    tmr_oe_i == 6'h00 && addr_en_i == 4'h0 && !addr_fixed && pat_en_i == `PORT_DATA_RST
      |=> pin_oe_o == $past(dir_eff) && ((pin_o ^ $past(st_reg.data)) & pin_oe_o) == 8'h00)
    else $error("port pin drive mismatch");

  // Direction register reads as all ones
  chk_dir_reads_ones: assert property (
    bus.rd_sel == SEL_DIR |=> hrdata_o == 32'(`PORT_DIR_READ) && hreadyout_o)
    else $error("direction read not all ones");

  // Port read mixes stored data and pin level by direction
  chk_read_mix: assert property (
    bus.rd_sel == SEL_DATA |=> hrdata_o == 32'(($past(dir_eff) & $past(st_reg.data))
      | (~$past(dir_eff) & $past(pin_i))))
    else $error("port read value wrong");

  // Both timers see the same external clock pins
  chk_clk_route: assert property (
    !reset_i |=> tmr16_clk_o == $past(pin_i[3:0]) && tmr8_clk_o == tmr16_clk_o)
    else $error("timer clock routing wrong");

  // Address output beats timer output in mode 5
  chk_addr_priority: assert property (
    addr_mode5 && addr_en_i[3] && tmr_oe_i[2] |=> pin_oe_o[4] && pin_o[4] == $past(addr_hi_i[3]))
    else $error("address bit 23 lost priority");

  // Timer output beats pattern and port drive
  chk_tmr_priority: assert property (
    tmr_oe_i[0] && !addr_fixed |=> pin_oe_o[2] && pin_o[2] == $past(tmr_out_i[0]))
    else $error("timer output lost priority");

  // Lower pin pattern output appears only with direction set
  chk_pattern_gate: assert property (
    pat_en_i[0] |=> pin_oe_o[0] == $past(dir_eff[0])
      && (!pin_oe_o[0] || pin_o[0] == $past(pat_out_i[0])))
    else $error("pattern output gating wrong");

  // A write holds the bus for exactly one wait cycle
  chk_write_wait: assert property (
    hsel_i && hready_i && htrans_i[1] && hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("write wait state wrong");
endmodule

//--- testbench/board_model.sv
// Purpose: Board side of the port pins, resolving the level seen on each pin
// Assumes: Pins with no driver on either side settle to the board level
// Notes: The board level is set once by the bench and kept for every scenario
module board_model
  import port_a_pkg::*;
(
  // From the port
  input wire port_a_pkg::port_t pin_drive_i,
  input wire port_a_pkg::port_t pin_oe_i,
  // Board side
  input wire port_a_pkg::port_t ext_level_i,
  // To the port
  output port_a_pkg::port_t pin_level_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Driven pins follow the port, the rest show the board level
  assign pin_level_o = (pin_drive_i & pin_oe_i) | (ext_level_i & ~pin_oe_i);
endmodule

//--- testbench/port_a_top_test.sv
// Purpose: Self-checking bench for the multiplexed port over AHB-Lite
// Assumes: One AHB master, the port as only slave
// Notes: Bus waits are bounded; a hang ends the run as a failure
`include "port_a_regs.svh"
module port_a_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  import port_a_pkg::*;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] rd;
  wire logic hreadyout;
  wire logic hresp;
  wire logic [31:0] hrdata;
  logic [2:0] mode = 3'h1;
  logic hw_standby = 1'b0;
  port_t ext = 8'h3C;
  port_t pat_en = 8'h00;
  port_t pat_out = 8'h00;
  wire port_t pin_lvl;
  wire port_t pin_o;
  wire port_t pin_oe;
  logic [5:0] tmr_oe = 6'h00;
  logic [5:0] tmr_out = 6'h00;
  wire logic [5:0] tmr_in;
  wire logic [3:0] clk16;
  wire logic [3:0] clk8;
  logic [3:0] addr_en = 4'h0;
  logic [3:0] addr_hi = 4'h5;
  int n_fail = 0;
  int checks = 0;

  // Free running clock
  always #2.5 clock_i = ~clock_i;

  port_a_top dut_u (.clock_i(clock_i), .reset_i(reset_i), .hsel_i(1'b1), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hwdata_i(hwdata), .hready_i(hreadyout),
    .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata), .mode_i(mode),
    .hw_standby_i(hw_standby), .pin_i(pin_lvl), .pin_o(pin_o), .pin_oe_o(pin_oe),
    .pat_en_i(pat_en), .pat_out_i(pat_out), .tmr_oe_i(tmr_oe), .tmr_out_i(tmr_out),
    .tmr_in_o(tmr_in), .tmr16_clk_o(clk16), .tmr8_clk_o(clk8), .addr_en_i(addr_en),
    .addr_hi_i(addr_hi));

  board_model board_u (.pin_drive_i(pin_o), .pin_oe_i(pin_oe), .ext_level_i(ext),
    .pin_level_o(pin_lvl));

  // Verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Compare a bus word
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Compare a pin vector
  task automatic chk_pins(input port_t got, input port_t exp, input string what);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Wait until hready is seen high, sampled between edges
  task automatic wait_ready;
    int n;
    n = 0;
    @(negedge clock_i);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        n_fail++;
        $display("MISMATCH %0t bus hang", $time);
        stop_test();
      end
      @(negedge clock_i);
    end
  endtask

  // One single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                     output logic [31:0] rdv);
    @(posedge clock_i);
    htrans <= 2'b10;
    haddr <= addr;
    hwrite <= wr;
    wait_ready();
    @(posedge clock_i);
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rdv = hrdata;
    @(posedge clock_i);
  endtask

  // Register write
  task automatic wr(input logic [31:0] addr, input logic [31:0] wd);
    logic [31:0] dummy;
    bus(1'b1, addr, wd, dummy);
  endtask

  // Let pin outputs settle, then stop between edges
  task automatic settle;
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
  endtask

  // Reset in a given mode
  task automatic do_reset(input logic [2:0] m);
    @(posedge clock_i);
    mode <= m;
    reset_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    reset_i <= 1'b0;
  endtask

  // Main sequence
  initial
  begin
    do_reset(3'h1);
    settle();
    chk_pins(pin_oe, 8'h00, "reset oe");
    bus(1'b0, `PORT_DATA_ADDR, 32'h0, rd);
    chk_word(rd, 32'h0000_003C, "reset data read");
    bus(1'b0, `PORT_DIR_ADDR, 32'h0, rd);
    chk_word(rd, 32'h0000_00FF, "dir read");
    chk_word({31'h0, hresp}, 32'h0000_0000, "okay response");
    $display("test reset done");
    // Mixed direction: outputs read back data, inputs read pins
    wr(`PORT_DIR_ADDR, 32'h0000_000F);
    wr(`PORT_DATA_ADDR, 32'h0000_00A5);
    bus(1'b0, `PORT_DATA_ADDR, 32'h0, rd);
    chk_word(rd, 32'h0000_0035, "mixed read");
    bus(1'b0, `PORT_DIR_ADDR, 32'h0, rd);
    chk_word(rd, 32'h0000_00FF, "dir read after write");
    settle();
    chk_pins(pin_oe, 8'h0F, "dir oe");
    chk_pins(pin_o & 8'h0F, 8'h05, "data out");
    chk_pins({4'h0, clk16}, {4'h0, pin_lvl[3:0]}, "clk16");
    chk_pins({4'h0, clk8}, {4'h0, pin_lvl[3:0]}, "clk8");
    chk_pins({2'b00, tmr_in}, {2'b00, pin_lvl[7:2]}, "timer in");
    bus(1'b0, 32'h0000_1000, 32'h0, rd);
    chk_word(rd, 32'h0000_0000, "unmapped");
    $display("test direction done");
    // Pattern output needs the direction bit
    @(posedge clock_i);
    pat_en <= 8'hF1;
    pat_out <= 8'h50;
    settle();
    chk_pins(pin_oe, 8'h0F, "pattern no dir");
    chk_pins(pin_o & 8'h0F, 8'h04, "pattern on pin 0");
    wr(`PORT_DIR_ADDR, 32'h0000_00FF);
    settle();
    chk_pins(pin_o, 8'h54, "pattern out");
    chk_pins(pin_oe, 8'hFF, "pattern oe");
    // Timer output beats port data
    @(posedge clock_i);
    pat_en <= 8'h00;
    tmr_oe <= 6'h01;
    settle();
    chk_pins(pin_o, 8'hA1, "timer priority");
    $display("test peripherals done");
    // Hardware standby clears both registers
    @(posedge clock_i);
    tmr_oe <= 6'h00;
    hw_standby <= 1'b1;
    @(posedge clock_i);
    hw_standby <= 1'b0;
    settle();
    chk_pins(pin_oe, 8'h00, "standby oe");
    wr(`PORT_DIR_ADDR, 32'h0000_00FF);
    bus(1'b0, `PORT_DATA_ADDR, 32'h0, rd);
    chk_word(rd, 32'h0000_0000, "standby data");
    settle();
    chk_pins(pin_o, 8'h00, "data drive after standby");
    $display("test standby done");
    // Mode 3: top pin is address bit 20 whatever is written
    do_reset(3'h3);
    settle();
    chk_pins(pin_oe, `PORT_TOP_MASK, "mode3 oe");
    chk_pins(pin_o, 8'h80, "mode3 addr20");
    wr(`PORT_DIR_ADDR, 32'h0000_0000);
    settle();
    chk_pins(pin_oe & `PORT_TOP_MASK, `PORT_TOP_MASK, "mode3 dir held");
    $display("test mode3 done");
    // Mode 5: pins 7 to 4 carry address bits 20 to 23
    do_reset(3'h5);
    settle();
    chk_pins(pin_oe, 8'h00, "mode5 reset oe");
    @(posedge clock_i);
    addr_en <= 4'hF;
    settle();
    chk_pins(pin_o, 8'hA0, "mode5 address");
    chk_pins(pin_oe, 8'hF0, "mode5 oe");
    @(posedge clock_i);
    tmr_oe <= 6'h04;
    tmr_out <= 6'h04;
    settle();
    chk_pins(pin_o, 8'hA0, "mode5 address over timer");
    $display("test mode5 done");
    stop_test();
  end
endmodule
